// >>> logic/ulb_pkg.sv
package ulb_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses on the AXI4-Lite port)
  // ------------------------------------------------------------
  localparam logic [3:0] ADDR_STATUS2 = 4'h0;  // lin_break_rx_status
  localparam logic [3:0] ADDR_CTRL    = 4'h4;  // frame format, standby, tx break request
  localparam logic [3:0] ADDR_STATUS1 = 4'h8;  // framing / receive-full / idle flags, data

  // ------------------------------------------------------------
  // lin_break_rx_status field positions
  // ------------------------------------------------------------
  localparam int BIT_LBRK   = 7;
  localparam int BIT_RXEDGE = 6;
  localparam int BIT_RSVD   = 5;
  localparam int BIT_RX_INVERT  = 4;
  localparam int BIT_WUID   = 3;
  localparam int BIT_LONGBK = 2;
  localparam int BIT_LIN_BREAK_DETECT_ENABLE  = 1;
  localparam int BIT_RAF    = 0;

  // control register fields
  localparam int BIT_NINE   = 0;   // 9-bit data
  localparam int BIT_TWOSTP = 1;   // two stop bits
  localparam int BIT_STBY   = 2;   // receiver standby
  localparam int BIT_SBK    = 3;   // send one break character (self-clearing)

  // status1 fields
  localparam int BIT_FE     = 0;
  localparam int BIT_RECEIVE_FULL_FLAG   = 1;
  localparam int BIT_IDLE   = 2;
  localparam int BIT_DATA   = 8;

  // ------------------------------------------------------------
  // frame and break lengths in bit times
  // ------------------------------------------------------------
  localparam logic [3:0] BASE_FRAME_BITS = 4'ha;  // start + 8 data + 1 stop
  localparam logic [3:0] BRK_DET_EXTRA   = 4'h1;  // lin detect threshold raise
  localparam logic [3:0] BRK_LONG_EXTRA  = 4'h3;  // long tx break
  localparam logic [3:0] IDLE_BITS       = 4'ha;  // idle character length
  localparam logic [7:0] RSP_OKAY        = 8'h00;
  localparam logic [1:0] RESP_OKAY       = 2'b00;
  localparam logic [1:0] RESP_SLVERR     = 2'b10;

  localparam int CLK_HZ = 50_000_000;

  // axi-lite carriers
  typedef struct packed {
    logic        awvalid;
    logic [3:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [3:0]  araddr;
    logic        rready;
  } ulb_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } ulb_axi_rsp_t;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'b001,
    RX_FRAME = 3'b010,
    RX_BREAK = 3'b100
  } ulb_rx_state_t;

endpackage : ulb_pkg

// >>> logic/ulb_bit_timer.sv
// bit-time tick generator; restart aligns the tick to mid-bit sampling
module ulb_bit_timer #(
  parameter int DIV = 434
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // control
  input  wire logic restart,
  // ticks
  output logic      midTick,
  output logic      endTick
);
  localparam int CW = $clog2(DIV + 1);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  localparam logic [CW-1:0] HALF = CW'(DIV / 2);

  initial begin
    if (DIV < 4) $error("bit divider too small");
  end

  logic [CW-1:0] cnt_q, cnt_d;

  always_comb begin
    if (restart || cnt_q == LAST) begin
      cnt_d = '0;
    end else begin
      cnt_d = cnt_q + CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign midTick = !restart && cnt_q == HALF;
  assign endTick = !restart && cnt_q == LAST;
endmodule : ulb_bit_timer

// >>> logic/ulb_lin_status.sv
module ulb_lin_status
  import ulb_pkg::*;
#(
  parameter int BIT_DIV = CLK_HZ / 115200
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          sys_rst,
  // register bus
  input  wire ulb_pkg::ulb_axi_req_t axiReq,
  output ulb_pkg::ulb_axi_rsp_t      axiRsp,
  // serial line
  input  wire logic          rxPin,
  output logic               txPin
);
  import ulb_pkg::*;

  initial begin
    if (BIT_DIV < 4) $error("BIT_DIV too small");
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic lbrkFlag_q, lbrkFlag_d, edgeFlag_q, edgeFlag_d;
  logic rx_invert_q, rx_invert_d, wuid_q, wuid_d, longBrk_q, longBrk_d, lin_break_detect_enable_q, lin_break_detect_enable_d;
  logic raf_q, raf_d;
  logic nine_q, nine_d, twoStop_q, twoStop_d, stby_q, stby_d;
  logic fe_q, fe_d, receive_full_flag_q, receive_full_flag_d, idle_q, idle_d;
  logic [7:0] data_q, data_d;
  ulb_axi_rsp_t rsp_q, rsp_d;
  logic awHeld_q, awHeld_d, wHeld_q, wHeld_d;
  logic [3:0] awAddr_q, awAddr_d;
  logic [31:0] wData_q, wData_d;
  logic [3:0] wStrb_q, wStrb_d;

  // receiver state
  ulb_rx_state_t rxSt_q, rxSt_d;
  logic rxLine_q, rxPrev_q;
  logic [3:0] bitCnt_q, bitCnt_d;      // bits seen in the current frame
  logic [3:0] zeroRun_q, zeroRun_d;    // consecutive low bits
  logic [3:0] oneRun_q, oneRun_d;      // consecutive high bits for idle
  logic idleArm_q, idleArm_d;
  logic [8:0] shift_q, shift_d;

  // transmitter state
  logic txBusy_q, txBusy_d, sbkReq_q, sbkReq_d, txPin_d;
  logic [3:0] txCnt_q, txCnt_d;

  // ------------------------------------------------------------
  // frame length and thresholds
  // ------------------------------------------------------------
  logic [3:0] frameBits, detBits, txBrkBits;
  always_comb begin
    frameBits = BASE_FRAME_BITS + {3'h0, nine_q} + {3'h0, twoStop_q};
    detBits   = lin_break_detect_enable_q ? frameBits + BRK_DET_EXTRA : frameBits;
    txBrkBits = longBrk_q ? frameBits + BRK_LONG_EXTRA : frameBits;
  end

  // ------------------------------------------------------------
  // receive line conditioning
  // ------------------------------------------------------------
  logic rxLevel;
  assign rxLevel = rxPin ^ rx_invert_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxLine_q <= 1'b1;
      rxPrev_q <= 1'b1;
    end else begin
      rxLine_q <= rxLevel;
      rxPrev_q <= rxLine_q;
    end
  end

  logic activeEdge;
  assign activeEdge = rxPrev_q && !rxLine_q;  // falling after inversion

  logic rxRestart, rxMid;
  assign rxRestart = (rxSt_q == RX_IDLE) && activeEdge;

  ulb_bit_timer #(.DIV(BIT_DIV)) u_rx_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .restart (rxRestart),
    .midTick (rxMid),
    .endTick ()
  );

  logic txTick;
  ulb_bit_timer #(.DIV(BIT_DIV)) u_tx_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .restart (1'b0),
    .midTick (),
    .endTick (txTick)
  );

  // ------------------------------------------------------------
  // receiver and status flags
  // ------------------------------------------------------------
  logic brkSeen, idleSeen, frameDone, stopBad;
  logic wrFire, wrS2, wrCtrl;
  logic [7:0] wByte;

  always_comb begin
    rxSt_d    = rxSt_q;
    bitCnt_d  = bitCnt_q;
    zeroRun_d = zeroRun_q;
    oneRun_d  = oneRun_q;
    idleArm_d = idleArm_q;
    shift_d   = shift_q;
    brkSeen   = 1'b0;
    idleSeen  = 1'b0;
    frameDone = 1'b0;
    stopBad   = 1'b0;
    unique case (rxSt_q)
      RX_IDLE: begin
        if (rxMid) begin
          if (rxLine_q) begin
            oneRun_d = (oneRun_q == IDLE_BITS) ? oneRun_q : oneRun_q + 4'h1;
            idleSeen = idleArm_q && (oneRun_q + 4'h1 == IDLE_BITS);
            if (idleSeen) idleArm_d = 1'b0;
          end else begin
            // valid start bit: still low at mid-bit
            rxSt_d    = RX_FRAME;
            bitCnt_d  = 4'h1;
            zeroRun_d = 4'h1;
            oneRun_d  = 4'h0;
          end
        end
      end
      RX_FRAME: begin
        if (rxMid) begin
          bitCnt_d  = bitCnt_q + 4'h1;
          zeroRun_d = rxLine_q ? 4'h0 : zeroRun_q + 4'h1;
          if (bitCnt_q <= frameBits - 4'h2 - {3'h0, twoStop_q}) begin
            shift_d = {rxLine_q, shift_q[8:1]};
          end
          if (!rxLine_q && zeroRun_q + 4'h1 == detBits) begin
            brkSeen = 1'b1;
            rxSt_d  = RX_BREAK;
          end else if (bitCnt_q + 4'h1 >= frameBits &&
                       !(lin_break_detect_enable_q && !rxLine_q && zeroRun_q == bitCnt_q)) begin
            // an all-low frame runs on past its stop bit so the raised threshold can be reached
            frameDone = 1'b1;
            stopBad   = zeroRun_q + 4'h1 != 4'h0 && !rxLine_q;
            rxSt_d    = RX_IDLE;
            idleArm_d = 1'b1;
          end
        end
      end
      RX_BREAK: begin
        if (rxMid && rxLine_q) begin
          rxSt_d    = RX_IDLE;
          oneRun_d  = 4'h1;
          idleArm_d = 1'b1;
        end
      end
      default: rxSt_d = RX_IDLE;
    endcase
  end

  always_comb begin
    lbrkFlag_d = lbrkFlag_q;
    edgeFlag_d = edgeFlag_q;
    rx_invert_d    = rx_invert_q;
    wuid_d     = wuid_q;
    longBrk_d  = longBrk_q;
    lin_break_detect_enable_d    = lin_break_detect_enable_q;
    nine_d     = nine_q;
    twoStop_d  = twoStop_q;
    stby_d     = stby_q;
    fe_d       = fe_q;
    receive_full_flag_d     = receive_full_flag_q;
    idle_d     = idle_q;
    data_d     = data_q;
    raf_d      = raf_q;
    if (wrS2) begin
      if (wByte[BIT_LBRK]) lbrkFlag_d = 1'b0;
      if (wByte[BIT_RXEDGE]) edgeFlag_d = 1'b0;
      rx_invert_d   = wByte[BIT_RX_INVERT];
      wuid_d    = wByte[BIT_WUID];
      longBrk_d = wByte[BIT_LONGBK];
      lin_break_detect_enable_d   = wByte[BIT_LIN_BREAK_DETECT_ENABLE];
    end
    if (wrCtrl) begin
      nine_d    = wByte[BIT_NINE];
      twoStop_d = wByte[BIT_TWOSTP];
      stby_d    = wByte[BIT_STBY];
    end
    if (wrFire && awAddr_d == ADDR_STATUS1 && wStrb_d[0]) begin
      // write-one-to-clear for the first status register
      if (wByte[BIT_FE]) fe_d = 1'b0;
      if (wByte[BIT_RECEIVE_FULL_FLAG]) receive_full_flag_d = 1'b0;
      if (wByte[BIT_IDLE]) idle_d = 1'b0;
    end
    // hardware sets win over software clears
    if (brkSeen && lin_break_detect_enable_q) lbrkFlag_d = 1'b1;
    if (activeEdge) edgeFlag_d = 1'b1;
    if (frameDone && !lin_break_detect_enable_q) begin
      receive_full_flag_d = 1'b1;
      // eight data bits end one place higher in the nine-bit shifter
      data_d = nine_q ? shift_d[7:0] : shift_d[8:1];
      if (stopBad) fe_d = 1'b1;
    end
    if (idleSeen && (!stby_q || wuid_q)) idle_d = 1'b1;
    if (rxSt_q == RX_IDLE && rxSt_d == RX_FRAME) raf_d = 1'b1;
    else if (idleSeen) raf_d = 1'b0;
  end

  // ------------------------------------------------------------
  // transmitter break generator
  // ------------------------------------------------------------
  always_comb begin
    txBusy_d = txBusy_q;
    txCnt_d  = txCnt_q;
    sbkReq_d = sbkReq_q;
    if (wrCtrl && wByte[BIT_SBK]) sbkReq_d = 1'b1;
    if (txTick) begin
      if (txBusy_q) begin
        txCnt_d = txCnt_q + 4'h1;
        if (txCnt_q + 4'h1 == txBrkBits) txBusy_d = 1'b0;
      end else if (sbkReq_q) begin
        txBusy_d = 1'b1;
        txCnt_d  = 4'h0;
        sbkReq_d = 1'b0;
      end
    end
    txPin_d = !txBusy_d;
  end

  // ------------------------------------------------------------
  // axi4-lite slave
  // ------------------------------------------------------------
  logic [7:0] s2Read;
  always_comb begin
    s2Read             = 8'h00;                // reserved bit stays zero
    s2Read[BIT_LBRK]   = lbrkFlag_q;
    s2Read[BIT_RXEDGE] = edgeFlag_q;
    s2Read[BIT_RX_INVERT]  = rx_invert_q;
    s2Read[BIT_WUID]   = wuid_q;
    s2Read[BIT_LONGBK] = longBrk_q;
    s2Read[BIT_LIN_BREAK_DETECT_ENABLE]  = lin_break_detect_enable_q;
    s2Read[BIT_RAF]    = raf_q;                // read only
  end

  logic addrOk;
  always_comb begin
    awHeld_d = awHeld_q;
    wHeld_d  = wHeld_q;
    awAddr_d = awAddr_q;
    wData_d  = wData_q;
    wStrb_d  = wStrb_q;
    rsp_d    = rsp_q;
    rsp_d.awready = 1'b0;
    rsp_d.wready  = 1'b0;
    rsp_d.arready = 1'b0;
    if (!awHeld_q && !rsp_q.bvalid && axiReq.awvalid && !rsp_q.awready) begin
      rsp_d.awready = 1'b1;
      awHeld_d      = 1'b1;
      awAddr_d      = axiReq.awaddr;
    end
    if (!wHeld_q && !rsp_q.bvalid && axiReq.wvalid && !rsp_q.wready) begin
      rsp_d.wready = 1'b1;
      wHeld_d      = 1'b1;
      wData_d      = axiReq.wdata;
      wStrb_d      = axiReq.wstrb;
    end
    wrFire = awHeld_q && wHeld_q && !rsp_q.bvalid;
    addrOk = awAddr_q == ADDR_STATUS2 || awAddr_q == ADDR_CTRL || awAddr_q == ADDR_STATUS1;
    if (wrFire) begin
      awHeld_d      = 1'b0;
      wHeld_d       = 1'b0;
      rsp_d.bvalid  = 1'b1;
      rsp_d.bresp   = addrOk ? RESP_OKAY : RESP_SLVERR;
    end else if (rsp_q.bvalid && axiReq.bready) begin
      rsp_d.bvalid = 1'b0;
    end
    if (rsp_q.rvalid) begin
      if (axiReq.rready) rsp_d.rvalid = 1'b0;
    end else if (axiReq.arvalid && !rsp_q.arready) begin
      rsp_d.arready = 1'b1;
      rsp_d.rvalid  = 1'b1;
      rsp_d.rresp   = RESP_OKAY;
      rsp_d.rdata   = 32'h0000_0000;
      unique case (axiReq.araddr)
        ADDR_STATUS2: rsp_d.rdata[7:0] = s2Read;
        ADDR_CTRL: rsp_d.rdata[3:0] = {sbkReq_q | txBusy_q, stby_q, twoStop_q, nine_q};
        ADDR_STATUS1: begin
          rsp_d.rdata[BIT_FE]   = fe_q;
          rsp_d.rdata[BIT_RECEIVE_FULL_FLAG] = receive_full_flag_q;
          rsp_d.rdata[BIT_IDLE] = idle_q;
          rsp_d.rdata[BIT_DATA +: 8] = data_q;
        end
        default: rsp_d.rresp = RESP_SLVERR;
      endcase
    end
  end

  assign wByte  = wData_q[7:0];
  assign wrS2   = wrFire && awAddr_q == ADDR_STATUS2 && wStrb_q[0];
  assign wrCtrl = wrFire && awAddr_q == ADDR_CTRL && wStrb_q[0];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lbrkFlag_q <= 1'b0;
      edgeFlag_q <= 1'b0;
      rx_invert_q    <= 1'b0;
      wuid_q     <= 1'b0;
      longBrk_q  <= 1'b0;
      lin_break_detect_enable_q    <= 1'b0;
      raf_q      <= 1'b0;
      nine_q     <= 1'b0;
      twoStop_q  <= 1'b0;
      stby_q     <= 1'b0;
      fe_q       <= 1'b0;
      receive_full_flag_q     <= 1'b0;
      idle_q     <= 1'b0;
      data_q     <= 8'h00;
      rsp_q      <= '0;
      awHeld_q   <= 1'b0;
      wHeld_q    <= 1'b0;
      awAddr_q   <= 4'h0;
      wData_q    <= 32'h0000_0000;
      wStrb_q    <= 4'h0;
      rxSt_q     <= RX_IDLE;
      bitCnt_q   <= 4'h0;
      zeroRun_q  <= 4'h0;
      oneRun_q   <= 4'h0;
      idleArm_q  <= 1'b0;
      shift_q    <= 9'h000;
      txBusy_q   <= 1'b0;
      txCnt_q    <= 4'h0;
      sbkReq_q   <= 1'b0;
      txPin      <= 1'b1;
    end else begin
      lbrkFlag_q <= lbrkFlag_d;
      edgeFlag_q <= edgeFlag_d;
      rx_invert_q    <= rx_invert_d;
      wuid_q     <= wuid_d;
      longBrk_q  <= longBrk_d;
      lin_break_detect_enable_q    <= lin_break_detect_enable_d;
      raf_q      <= raf_d;
      nine_q     <= nine_d;
      twoStop_q  <= twoStop_d;
      stby_q     <= stby_d;
      fe_q       <= fe_d;
      receive_full_flag_q     <= receive_full_flag_d;
      idle_q     <= idle_d;
      data_q     <= data_d;
      rsp_q      <= rsp_d;
      awHeld_q   <= awHeld_d;
      wHeld_q    <= wHeld_d;
      awAddr_q   <= awAddr_d;
      wData_q    <= wData_d;
      wStrb_q    <= wStrb_d;
      rxSt_q     <= rxSt_d;
      bitCnt_q   <= bitCnt_d;
      zeroRun_q  <= zeroRun_d;
      oneRun_q   <= oneRun_d;
      idleArm_q  <= idleArm_d;
      shift_q    <= shift_d;
      txBusy_q   <= txBusy_d;
      txCnt_q    <= txCnt_d;
      sbkReq_q   <= sbkReq_d;
      txPin      <= txPin_d;
    end
  end

  assign axiRsp = rsp_q;
endmodule : ulb_lin_status

// >>> dv/ulb_lin_status_assertions.sv
module ulb_lin_status_assertions
  import ulb_pkg::*;
#(
  parameter int BIT_DIV = 8
) (
  // clock and reset
  input wire logic                  clk,
  input wire logic                  sys_rst,
  // register bus
  input wire ulb_pkg::ulb_axi_req_t axiReq,
  input wire ulb_pkg::ulb_axi_rsp_t axiRsp,
  // serial line
  input wire logic                  rxPin,
  input wire logic                  txPin
);
  // ------------------------------------------------------------
  // helper state
  // ------------------------------------------------------------
  logic inv_q;
  int   txLow_q;
  int   rxIdle_q;

  // inversion is shadowed from bus writes so idle is judged as the receiver sees it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      inv_q <= 1'b0;
      txLow_q <= 0;
      rxIdle_q <= 0;
    end else begin
      if (axiReq.wvalid && axiRsp.wready && axiReq.awaddr == ADDR_STATUS2) begin
        inv_q <= axiReq.wdata[BIT_RX_INVERT];
      end
      txLow_q <= txPin ? 0 : txLow_q + 1;
      rxIdle_q <= (rxPin ^ inv_q) ? rxIdle_q + 1 : 0;
    end
  end

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  a_rsvd_reads_zero: assert property (@(posedge clk) disable iff (sys_rst)
    axiRsp.rvalid && axiReq.araddr == ADDR_STATUS2 |-> !axiRsp.rdata[BIT_RSVD])
    else $error("reserved status bit read as one");
  a_tx_break_max: assert property (@(posedge clk) disable iff (sys_rst)
    txLow_q <= 15 * BIT_DIV)
    else $error("transmit line low longer than the longest break");
  a_raf_idle_clear: assert property (@(posedge clk) disable iff (sys_rst)
    axiRsp.rvalid && axiReq.araddr == ADDR_STATUS2 && rxIdle_q > 24 * BIT_DIV
    |-> !axiRsp.rdata[BIT_RAF])
    else $error("receiver active still set on an idle line");
  a_b_hold: assert property (@(posedge clk) disable iff (sys_rst)
    axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid)
    else $error("write response dropped before taken");
  a_r_hold: assert property (@(posedge clk) disable iff (sys_rst)
    axiRsp.rvalid && !axiReq.rready |=> axiRsp.rvalid && $stable(axiRsp.rdata))
    else $error("read data dropped or changed before taken");
  a_rd_answer: assert property (@(posedge clk) disable iff (sys_rst)
    axiReq.arvalid && !axiRsp.arready && !axiRsp.rvalid |-> ##[1:4] axiRsp.rvalid)
    else $error("read not answered in time");
  a_unmapped_err: assert property (@(posedge clk) disable iff (sys_rst)
    axiRsp.rvalid && axiReq.araddr == 4'hc |-> axiRsp.rresp == RESP_SLVERR && axiRsp.rdata == 0)
    else $error("unmapped read not refused");
  a_tx_idle_rst: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(sys_rst) |-> txPin && !axiRsp.bvalid && !axiRsp.rvalid)
    else $error("outputs not idle after reset");
endmodule : ulb_lin_status_assertions

bind ulb_lin_status ulb_lin_status_assertions #(.BIT_DIV(BIT_DIV)) ulb_lin_status_assertions_inst (
  .clk(clk), .sys_rst(sys_rst), .axiReq(axiReq), .axiRsp(axiRsp), .rxPin(rxPin), .txPin(txPin));

// >>> dv/ulb_remote_node.sv
module ulb_remote_node #(
  parameter int BIT_DIV = 8
) (
  // clock
  input  wire logic clk,
  // serial line
  output logic      rxPin,
  input  wire logic txPin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic line;
  logic inv;
  int   lowRun;
  int   lastLow;

  // inv models an inverting transceiver: idle then sits low on the wire
  assign rxPin = line ^ inv;

  initial begin
    line = 1'b1;
    inv = 1'b0;
    lowRun = 0;
    lastLow = 0;
  end

  // length of the last low run on the transmit line, in clocks
  always @(posedge clk) begin
    lowRun <= txPin ? 0 : lowRun + 1;
    if (txPin && lowRun != 0) lastLow <= lowRun;
  end

  task automatic hold(input logic b, input int n);
    @(posedge clk);
    line <= b;
    repeat (n * BIT_DIV - 1) @(posedge clk);
  endtask : hold

  task automatic send_frame(input logic [7:0] d, input logic stopLvl);
    hold(1'b0, 1);
    for (int i = 0; i < 8; i++) hold(d[i], 1);
    hold(stopLvl, 1);
    hold(1'b1, 1);
  endtask : send_frame

  task automatic send_low(input int n);
    hold(1'b0, n);
    hold(1'b1, 1);
  endtask : send_low
endmodule : ulb_remote_node

// >>> dv/ulb_lin_status_tb_top.sv
module ulb_lin_status_tb_top
  import ulb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BD = 8;
  logic         clk;
  logic         sys_rst;
  ulb_axi_req_t axiReq;
  ulb_axi_rsp_t axiRsp;
  logic         rxPin;
  logic         txPin;
  logic [31:0]  rd;
  logic [1:0]   rr;
  int           nErrors;
  int           checksDone;
  int           thr;
  int           n;

  ulb_lin_status #(.BIT_DIV(BD)) ulb_lin_status_inst (
    .clk(clk), .sys_rst(sys_rst), .axiReq(axiReq), .axiRsp(axiRsp), .rxPin(rxPin), .txPin(txPin));
  ulb_remote_node #(.BIT_DIV(BD)) ulb_remote_node_inst (.clk(clk), .rxPin(rxPin), .txPin(txPin));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ------------------------------------------------------------
  // bus and check tasks
  // ------------------------------------------------------------
  task automatic finish_test();
    if (nErrors == 0 && checksDone > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      nErrors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic guard(input int k);
    if (k > 300) begin
      nErrors++;
      finish_test();
    end
  endtask : guard

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    int k;
    @(posedge clk);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr <= a;
    axiReq.wvalid <= 1'b1;
    axiReq.wdata <= {24'h0, d};
    axiReq.bready <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
      guard(k);
      if (axiRsp.awready) axiReq.awvalid <= 1'b0;
      if (axiRsp.wready) axiReq.wvalid <= 1'b0;
    end while (!axiRsp.bvalid);
    axiReq.bready <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [3:0] a);
    int k;
    @(posedge clk);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr <= a;
    axiReq.rready <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
      guard(k);
      if (axiRsp.arready) axiReq.arvalid <= 1'b0;
    end while (!axiRsp.rvalid);
    rd = axiRsp.rdata;
    rr = axiRsp.rresp;
    axiReq.rready <= 1'b0;
  endtask : rdr

  task automatic chk_rd(input string w, input logic [3:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    rdr(a);
    check(w, rd & m, e);
  endtask : chk_rd

  task automatic bits(input int k);
    repeat (k * BD) @(posedge clk);
  endtask : bits

  // let the line settle, then drop every sticky flag
  task automatic clr(input logic [7:0] s2);
    bits(24);
    wr(ADDR_STATUS1, 8'h07);
    wr(ADDR_STATUS2, s2 | 8'hc0);
  endtask : clr

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    axiReq = '0;
    axiReq.wstrb = 4'hf;
    sys_rst = 1'b1;
    nErrors = 0;
    checksDone = 0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    chk_rd("s2 reset", ADDR_STATUS2, 32'hff, 32'h0);
    chk_rd("s1 reset", ADDR_STATUS1, 32'h7, 32'h0);
    wr(ADDR_STATUS2, 8'hef);
    chk_rd("s2 write", ADDR_STATUS2, 32'hff, 32'h0e);
    rdr(4'hc);
    check("unmapped", {30'h0, rr}, {30'h0, RESP_SLVERR});
    wr(ADDR_STATUS2, 8'h00);
    fork
      ulb_remote_node_inst.send_frame(8'h55, 1'b1);
      begin
        bits(3);
        chk_rd("raf busy", ADDR_STATUS2, 32'h1, 32'h1);
      end
    join
    bits(12);
    chk_rd("edge flag", ADDR_STATUS2, 32'h41, 32'h40);
    chk_rd("frame", ADDR_STATUS1, 32'hff03, 32'h5502);
    wr(ADDR_STATUS2, 8'h00);
    chk_rd("edge w0", ADDR_STATUS2, 32'h40, 32'h40);
    wr(ADDR_STATUS2, 8'h40);
    chk_rd("edge w1", ADDR_STATUS2, 32'h40, 32'h0);
    ulb_remote_node_inst.inv <= 1'b1;
    wr(ADDR_STATUS2, 8'h10);
    clr(8'h10);
    ulb_remote_node_inst.send_frame(8'h0f, 1'b1);
    bits(12);
    chk_rd("inv edge", ADDR_STATUS2, 32'h41, 32'h40);
    chk_rd("inv frame", ADDR_STATUS1, 32'hff03, 32'h0f02);
    ulb_remote_node_inst.inv <= 1'b0;
    wr(ADDR_STATUS2, 8'h00);
    clr(8'h00);
    for (int ls = 0; ls < 2; ls++) begin
      wr(ADDR_STATUS2, 8'(ls << BIT_LONGBK));
      ulb_remote_node_inst.send_frame(8'h81, 1'b0);
      bits(2);
      chk_rd("bad stop", ADDR_STATUS1, 32'h3, 32'h3);
      chk_rd("no lin", ADDR_STATUS2, 32'h80, 32'h0);
      clr(8'(ls << BIT_LONGBK));
    end
    for (int f = 0; f < 4; f++) begin
      thr = 11 + f[0] + f[1];
      wr(ADDR_CTRL, 8'(f));
      wr(ADDR_STATUS2, 8'h02);
      clr(8'h02);
      ulb_remote_node_inst.send_low(thr - 1);
      bits(12);
      chk_rd("short brk", ADDR_STATUS2, 32'h80, 32'h0);
      chk_rd("no fe", ADDR_STATUS1, 32'h3, 32'h0);
      ulb_remote_node_inst.send_low(thr + 1);
      bits(12);
      chk_rd("lin brk", ADDR_STATUS2, 32'h80, 32'h80);
      chk_rd("no fe brk", ADDR_STATUS1, 32'h3, 32'h0);
      wr(ADDR_STATUS2, 8'h02);
      chk_rd("lin w0", ADDR_STATUS2, 32'h80, 32'h80);
      wr(ADDR_STATUS2, 8'h82);
      chk_rd("lin w1", ADDR_STATUS2, 32'h80, 32'h0);
    end
    for (int k = 0; k < 8; k++) begin
      wr(ADDR_STATUS2, 8'(k[2] << BIT_LONGBK));
      wr(ADDR_CTRL, 8'((k & 3) | 8));
      n = 0;
      do begin
        bits(1);
        n++;
        guard(n);
        rdr(ADDR_CTRL);
      end while (rd[BIT_SBK]);
      bits(2);
      check("tx brk", ulb_remote_node_inst.lastLow, (10 + k[0] + k[1] + 3 * k[2]) * BD);
    end
    wr(ADDR_CTRL, 8'h00);
    for (int w = 0; w < 2; w++) begin
      wr(ADDR_STATUS2, 8'(w << BIT_WUID));
      wr(ADDR_STATUS1, 8'h07);
      wr(ADDR_CTRL, 8'h04);
      ulb_remote_node_inst.send_frame(8'h33, 1'b1);
      bits(14);
      chk_rd("stby idle", ADDR_STATUS1, 32'h4, 32'(w << BIT_IDLE));
    end
    finish_test();
  end
endmodule : ulb_lin_status_tb_top
